// ===== src/slr_regs.sv
// serial link receiver configuration and status registers behind spi
// assumes spi pins come from outside the clock domain, link-side status
// and control come from logic on clk_sys
`timescale 1ns/1ps

module slr_regs
    import slr_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic spi_sclk,
    input wire logic spi_cs_b,
    input wire logic spi_sdi,
    output logic spi_sdo_o,
    output logic spi_sdo_oe,
    input wire logic link_enable_control,
    input wire logic link_encoding_select,
    input wire logic subclass_one,
    input wire logic [7:0] octets_per_frame_f,
    input wire logic [7:0] multiblocks_per_emb_e,
    input wire slr_status_in_t status_in,
    output slr_cfg_out_t cfg_out
);

    // pin synchronisers; stage one is read only by stage two
    logic sclk_meta_q, cs_meta_q, sdi_meta_q;
    logic sclk_sync_q, cs_sync_q, sdi_sync_q;
    logic sclk_prev_q;

    logic [4:0] bit_cnt_q;
    logic [22:0] shift_q;
    logic [7:0] rd_byte_q;
    logic sdo_q, sdo_oe_q;

    logic [7:0] mode_reg_q, kfield_q, delay_reg_q;
    logic eb_fault_q, realigned_q;
    slr_cfg_out_t cfg_q;

    wire sclk_rise = sclk_sync_q & ~sclk_prev_q & ~cs_sync_q;
    wire sclk_fall = ~sclk_sync_q & sclk_prev_q & ~cs_sync_q;
    wire [4:0] bit_cnt_inc = bit_cnt_q + 5'h01;
    wire addr_done = sclk_rise && (bit_cnt_inc == SLR_ADDR_END);
    wire frame_done = sclk_rise && (bit_cnt_inc == SLR_FRAME_END);
    // at the 16th rise the shift register holds rw flag and 14 address bits; sdi gives the last
    wire [14:0] hdr_addr = {shift_q[13:0], sdi_sync_q};
    wire hdr_is_read = shift_q[14];
    // bit 22 still holds the rw flag at the 24th rise
    wire [14:0] wr_addr = shift_q[21:7];
    wire [7:0] wr_data = {shift_q[6:0], sdi_sync_q};
    wire wr_is_write = ~shift_q[SLR_RW_POS - 1];
    wire wr_stb = frame_done && wr_is_write;

    wire wr_mode = wr_stb && (wr_addr == SLR_OFS_SYNC_WORD_MODE);
    wire wr_kfield = wr_stb && (wr_addr == SLR_OFS_FRAMES_PER_MF);
    wire wr_delay = wr_stb && (wr_addr == SLR_OFS_RELEASE_DELAY);
    wire wr_status = wr_stb && (wr_addr == SLR_OFS_LINK_STATUS);

    // sticky flags: a new event wins over a clear in the same cycle
    wire clr_eb = wr_status && wr_data[SLR_ST_EB_FAULT];
    wire clr_realign = wr_status && wr_data[SLR_ST_REALIGNED];
    wire eb_fault_d = status_in.eb_fault_evt | (eb_fault_q & ~clr_eb);
    wire realigned_d = status_in.realign_evt | (realigned_q & ~clr_realign);

    wire [7:0] status_rd = {eb_fault_q, status_in.link_up,
        status_in.sync_line_level, realigned_q,
        status_in.sysref_consistent_flag,
        status_in.pll_locked, 2'b00};

    function automatic logic [7:0] rd_mux(input logic [14:0] a,
                                          input logic [7:0] st);
        logic [7:0] r;
        r = 8'h00;
        if (a == SLR_OFS_SYNC_WORD_MODE) begin
            r = mode_reg_q;
        end else if (a == SLR_OFS_FRAMES_PER_MF) begin
            r = kfield_q;
        end else if (a == SLR_OFS_RELEASE_DELAY) begin
            r = delay_reg_q;
        end else if (a == SLR_OFS_LINK_STATUS) begin
            r = st;
        end
        return r;
    endfunction

    // effective k: 256*e/f in 64b/66b, field+1 in 8b/10b
    wire [15:0] scaled_e = {multiblocks_per_emb_e, 8'h00};
    wire [15:0] k_wide_f = {8'h00, octets_per_frame_f};
    wire [15:0] k_64b66b = (octets_per_frame_f == 8'h00) ? 16'h0000 :
        scaled_e / k_wide_f;
    wire [15:0] k_8b10b = {8'h00, kfield_q} + 16'h0001;
    wire [5:0] delay_field = delay_reg_q[SLR_DELAY_MSB:0];

    slr_cfg_out_t cfg_d;
    always_comb begin
        cfg_d = '0;
        cfg_d.sync_header_word_select = mode_reg_q[SLR_MODE_MSB:0];
        // crc only matters with 64b/66b; reserved codes check nothing
        cfg_d.crc12_check_en = link_encoding_select &&
            (mode_reg_q[SLR_MODE_MSB:0] == SLR_MODE_CRC12);
        cfg_d.cmd_fields_used = 1'b0;
        cfg_d.frames_per_multiframe_less_one = kfield_q;
        cfg_d.effective_k = link_encoding_select ? k_64b66b :
            k_8b10b;
        cfg_d.release_buffer_delay = delay_field;
        // only subclass 1 shifts the release past the boundary
        cfg_d.release_offset_octets = subclass_one ?
            {delay_field, 2'b00} : 8'h00;
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            sclk_meta_q <= 1'b0;
            sclk_sync_q <= 1'b0;
            sclk_prev_q <= 1'b0;
            cs_meta_q <= 1'b1;
            cs_sync_q <= 1'b1;
            sdi_meta_q <= 1'b0;
            sdi_sync_q <= 1'b0;
        end else if (clk_en) begin
            sclk_meta_q <= spi_sclk;
            sclk_sync_q <= sclk_meta_q;
            sclk_prev_q <= sclk_sync_q;
            cs_meta_q <= spi_cs_b;
            cs_sync_q <= cs_meta_q;
            sdi_meta_q <= spi_sdi;
            sdi_sync_q <= sdi_meta_q;
        end
    end

    // spi frame engine
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            bit_cnt_q <= 5'h00;
            shift_q <= '0;
            rd_byte_q <= 8'h00;
        end else if (clk_en) begin
            if (cs_sync_q) begin
                bit_cnt_q <= 5'h00;
            end else if (sclk_rise) begin
                bit_cnt_q <= frame_done ? 5'h00 : bit_cnt_inc;
                shift_q <= {shift_q[21:0], sdi_sync_q};
            end
            if (addr_done) begin
                rd_byte_q <= hdr_is_read ? rd_mux(hdr_addr, status_rd) :
                    8'h00;
            end
        end
    end

    // read data leaves on falling sclk so the host samples it on rising
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            sdo_q <= 1'b0;
            sdo_oe_q <= 1'b0;
        end else if (clk_en) begin
            sdo_oe_q <= ~cs_sync_q;
            if (cs_sync_q) begin
                sdo_q <= 1'b0;
            end else if (sclk_fall && (bit_cnt_q >= SLR_ADDR_END)) begin
                sdo_q <= rd_byte_q[3'(SLR_FRAME_END - 5'h01 - bit_cnt_q)];
            end
        end
    end

    // software is expected to write these only with the link disabled;
    // the bank does not block writes, so the link sees any change at once
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            mode_reg_q <= SLR_RST_SYNC_WORD_MODE;
            kfield_q <= SLR_RST_FRAMES_PER_MF;
            delay_reg_q <= SLR_RST_RELEASE_DELAY;
        end else if (clk_en) begin
            if (wr_mode) begin
                mode_reg_q <= wr_data;
            end
            if (wr_kfield) begin
                kfield_q <= wr_data;
            end
            if (wr_delay) begin
                delay_reg_q <= wr_data;
            end
        end
    end

    // sticky status; live bits are read straight through
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            eb_fault_q <= 1'b0;
            realigned_q <= 1'b0;
        end else if (clk_en) begin
            eb_fault_q <= eb_fault_d;
            realigned_q <= realigned_d;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            cfg_q <= '0;
        end else if (clk_en) begin
            cfg_q <= cfg_d;
        end
    end

    assign spi_sdo_o = sdo_q;
    assign spi_sdo_oe = sdo_oe_q;
    assign cfg_out = cfg_q;

endmodule

// ===== src/slr_pkg.sv
// package for the serial link receiver configuration and status bank
// assumes one 10 MHz system clock and an spi host far slower than it
package slr_pkg;
    localparam int SLR_CLK_HZ = 10_000_000;
    // spi frame: read flag, 15-bit address, 8-bit data, msb first
    localparam int SLR_FRAME_BITS = 24;
    localparam int SLR_ADDR_BITS = 15;
    localparam int SLR_DATA_BITS = 8;
    localparam logic [4:0] SLR_ADDR_END = 5'h10;
    localparam logic [4:0] SLR_FRAME_END = 5'h18;
    localparam logic [4:0] SLR_RW_POS = 5'h17;

    localparam logic [14:0] SLR_OFS_SYNC_WORD_MODE = 15'h0104;
    localparam logic [14:0] SLR_OFS_FRAMES_PER_MF = 15'h0105;
    localparam logic [14:0] SLR_OFS_RELEASE_DELAY = 15'h0106;
    localparam logic [14:0] SLR_OFS_LINK_STATUS = 15'h0107;

    localparam logic [7:0] SLR_RST_SYNC_WORD_MODE = 8'h00;
    localparam logic [7:0] SLR_RST_FRAMES_PER_MF = 8'h1F;
    localparam logic [7:0] SLR_RST_RELEASE_DELAY = 8'h00;

    // field layout
    localparam int SLR_MODE_MSB = 1;
    localparam int SLR_DELAY_MSB = 5;
    localparam logic [1:0] SLR_MODE_CRC12 = 2'h0;
    localparam int SLR_ST_EB_FAULT = 7;
    localparam int SLR_ST_LINK_UP = 6;
    localparam int SLR_ST_SYNC_LEVEL = 5;
    localparam int SLR_ST_REALIGNED = 4;
    localparam int SLR_ST_CONSISTENT = 3;
    localparam int SLR_ST_PLL_LOCKED = 2;
    // each delay step moves the release opportunity by four octets
    localparam int SLR_DELAY_STEP_SHIFT = 2;
    // multiblock scale for effective frames per multiframe in 64b/66b
    localparam int SLR_MBLK_SCALE_SHIFT = 8;

    typedef struct packed {
        logic eb_fault_evt;      // one-cycle pulse on under/overflow
        logic realign_evt;       // one-cycle pulse on sysref realign
        logic link_up;           // elastic buffer released
        logic sync_line_level;   // 1 = sync de-asserted
        logic sysref_consistent_flag;
        logic pll_locked;        // all enabled serdes plls locked
    } slr_status_in_t;

    typedef struct packed {
        logic [1:0] sync_header_word_select;
        logic crc12_check_en;
        logic cmd_fields_used;
        logic [7:0] frames_per_multiframe_less_one;
        logic [15:0] effective_k;
        logic [5:0] release_buffer_delay;
        logic [7:0] release_offset_octets;
    } slr_cfg_out_t;
endpackage

// ===== testbench/slr_regs_chk.sv
// assertions on the link config/status bank ports
// assumes one clock domain and the package field layout
`timescale 1ns/1ps
module slr_regs_chk
    import slr_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic spi_cs_b,
    input wire logic spi_sdo_oe,
    input wire logic link_encoding_select,
    input wire logic subclass_one,
    input wire logic [7:0] octets_per_frame_f,
    input wire logic [7:0] multiblocks_per_emb_e,
    input wire slr_cfg_out_t cfg_out
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    a_crc_mode_zero: assert property (
        $past(rst_b) |-> cfg_out.crc12_check_en == ($past(link_encoding_select)
        && cfg_out.sync_header_word_select == 2'h0)) else $error("crc en");
    a_mode_only_wide: assert property (
        $past(rst_b) && !$past(link_encoding_select)
        |-> !cfg_out.crc12_check_en) else $error("crc in 8b10b");
    a_no_cmd_use: assert property (
        cfg_out.cmd_fields_used == 1'b0) else $error("cmd used");
    a_k_narrow: assert property (
        $past(rst_b) && !$past(link_encoding_select) |-> cfg_out.effective_k ==
        16'(cfg_out.frames_per_multiframe_less_one) + 16'h0001)
        else $error("k 8b10b");
    a_k_wide: assert property (
        $past(rst_b) && $past(link_encoding_select)
        && $past(octets_per_frame_f) != 8'h00 |-> cfg_out.effective_k ==
        16'($past(multiblocks_per_emb_e)) * 16'h0100
        / 16'($past(octets_per_frame_f))) else $error("k 64b66b");
    a_delay_offset: assert property (
        $past(rst_b) |-> cfg_out.release_offset_octets == ($past(subclass_one)
        ? {cfg_out.release_buffer_delay, 2'b00} : 8'h00)) else $error("ofs");
    a_reset_load: assert property (
        rst_b && !$past(rst_b) |=> cfg_out.frames_per_multiframe_less_one ==
        8'h1F && cfg_out.sync_header_word_select == 2'h0
        && cfg_out.release_buffer_delay == 6'h00) else $error("reset vals");
    a_sdo_quiet: assert property (
        spi_cs_b [*5] |-> !spi_sdo_oe) else $error("sdo driven idle");
endmodule
bind slr_regs slr_regs_chk slr_regs_chk_inst (.clk_sys, .rst_b, .spi_cs_b,
    .spi_sdo_oe, .link_encoding_select, .subclass_one, .octets_per_frame_f,
    .multiblocks_per_emb_e, .cfg_out);

// ===== testbench/slr_link_tx_model.sv
// link transmitter stand-in feeding the status inputs
// assumes the bench sets levels and requests events on clk_sys
`timescale 1ns/1ps
module slr_link_tx_model
    import slr_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [3:0] lvl,
    input wire logic go_fault,
    input wire logic go_sysref,
    output slr_status_in_t status_in
);
    logic fault_q;
    logic [3:0] burst_q;
    // odd counts give seven separate realign pulses per request
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            fault_q <= 1'b0;
            burst_q <= 4'h0;
        end else begin
            fault_q <= go_fault;
            burst_q <= go_sysref ? 4'hE : burst_q - 4'(burst_q != 4'h0);
        end
    end
    assign status_in = {fault_q, burst_q[0], lvl};
endmodule

// ===== testbench/testbench.sv
// self-checking bench for the link config/status bank over spi
// assumes 24-bit mode 0 spi frames and one 10 MHz clock
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin fail_count++; \
    $display("[ERR] t=%0t got %0h exp %0h", $time, g, e); end end
module testbench
    import slr_pkg::*;
;
    logic clk_sys = 1'b0, rst_b = 1'b0, sclk = 1'b0, cs_b = 1'b1, sdi = 1'b0;
    logic enc = 1'b0, sub1 = 1'b0, gof = 1'b0, gos = 1'b0, len = 1'b0;
    logic [7:0] f_oct = 8'h04, e_mb = 8'h02;
    logic [3:0] lvl = 4'h0;
    logic sdo, sdo_oe;
    slr_status_in_t st;
    slr_cfg_out_t cfg;
    int fail_count = 0, check_count = 0;
    slr_regs slr_regs_inst (.clk_sys(clk_sys), .rst_b(rst_b), .clk_en(1'b1),
        .spi_sclk(sclk), .spi_cs_b(cs_b), .spi_sdi(sdi), .spi_sdo_o(sdo),
        .spi_sdo_oe(sdo_oe), .link_enable_control(len),
        .link_encoding_select(enc), .subclass_one(sub1),
        .octets_per_frame_f(f_oct), .multiblocks_per_emb_e(e_mb),
        .status_in(st), .cfg_out(cfg));
    slr_link_tx_model slr_link_tx_model_inst (.clk_sys(clk_sys),
        .rst_b(rst_b), .lvl(lvl), .go_fault(gof), .go_sysref(gos),
        .status_in(st));
    initial begin
        forever #50 clk_sys = ~clk_sys;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic spi(input logic [23:0] fr, output logic [7:0] d);
        cs_b = 1'b0;
        d = 8'h00;
        tick(4);
        for (int i = 23; i >= 0; i--) begin
            sdi = fr[i];
            tick(5);
            if (i < 8) d[i] = sdo;
            sclk = 1'b1;
            tick(5);
            sclk = 1'b0;
        end
        tick(4);
        cs_b = 1'b1;
        sdi = ~sdi;
        tick(8);
    endtask
    task automatic wr(input logic [14:0] a, input logic [7:0] v);
        logic [7:0] unused;
        spi({1'b0, a, v}, unused);
    endtask
    task automatic rd_chk(input logic [14:0] a, input logic [7:0] e);
        logic [7:0] got;
        spi({1'b1, a, 8'h00}, got);
        `CHK(got, e)
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        tick(40000);
        fail_count++;
        print_verdict();
    end
    initial begin
        logic [7:0] rst_v [5] = '{8'h00, 8'h1F, 8'h00, 8'h00, 8'h00};
        tick(16);
        rst_b = 1'b1;
        tick(4);
        // 0x108 is unmapped and must read zero
        for (int i = 0; i < 5; i++)
            rd_chk(SLR_OFS_SYNC_WORD_MODE + 15'(i), rst_v[i]);
        enc = 1'b1;
        for (int m = 3; m >= 0; m--) begin
            wr(SLR_OFS_SYNC_WORD_MODE, 8'(m));
            `CHK(cfg.crc12_check_en, 1'(m == 0))
            `CHK(cfg.cmd_fields_used, 1'b0)
        end
        enc = 1'b0;
        tick(2);
        `CHK(cfg.crc12_check_en, 1'b0)
        wr(SLR_OFS_FRAMES_PER_MF, 8'hFF);
        `CHK(cfg.effective_k, 16'h0100)
        wr(SLR_OFS_FRAMES_PER_MF, 8'h07);
        rd_chk(SLR_OFS_FRAMES_PER_MF, 8'h07);
        `CHK(cfg.effective_k, 16'h0008)
        wr(SLR_OFS_RELEASE_DELAY, 8'h07);
        `CHK(cfg.release_buffer_delay, 6'h07)
        enc = 1'b1;
        tick(2);
        `CHK(cfg.effective_k, 16'h0080)
        sub1 = 1'b1;
        wr(SLR_OFS_RELEASE_DELAY, 8'hFF);
        rd_chk(SLR_OFS_RELEASE_DELAY, 8'hFF);
        `CHK(cfg.release_offset_octets, 8'hFC)
        sub1 = 1'b0;
        tick(2);
        `CHK(cfg.release_offset_octets, 8'h00)
        len = 1'b1; // settings stay untouched from here on
        lvl = 4'hF;
        tick(2);
        rd_chk(SLR_OFS_LINK_STATUS, 8'h6C);
        gof = 1'b1;
        gos = 1'b1;
        tick(1);
        gof = 1'b0;
        gos = 1'b0;
        tick(20);
        lvl = 4'h0;
        wr(SLR_OFS_LINK_STATUS, 8'h6F);
        rd_chk(SLR_OFS_LINK_STATUS, 8'h90);
        lvl = 4'h2;
        wr(SLR_OFS_LINK_STATUS, 8'hFF);
        rd_chk(SLR_OFS_LINK_STATUS, 8'h08);
        print_verdict();
    end
endmodule
